// *** rtl/srft_top.v ***
// Contract
// R1 - 782x492 array; left 26 columns, top 8 rows black
// R2 - raw mode outputs middle four black rows
// R3 - at most 753 by 481 active
// R4 - colour bit: offset from first-green only, else all dark
// R5 - binning joins direct neighbours only
// R6 - interlaced colour fields hold red/green or blue/green rows
// R7 - output framed by programmable blanking
// R8 - one 10-bit pixel per pixel clock in line valid
// R9 - unbinned pixel clock is inverted master clock
// R10 - bin 2: one master period high/low; bin 4: two periods each
// R11 - pixel clock toggles in blanking too
// R12 - polarity bit inverts pixel clock
// R13 - row is width plus blanking; start blank hblank-23, end blank 23
// R14 - vertical blanking is vblank rows times row time plus 4
// R15 - frame valid is rows times row time
// R16 - long integration stretches vertical blanking
// R17 - simultaneous mode extends blanking, register kept
// R18 - vertical blanking never alters exposure
// R19 - row time never below 660 columns
// R20 - host programs hblank at least 43, more if width below 617
// R21 - same corrections for every colour
// R22 - host samples data on rising pixel clock edge
// R23 - output enable low releases only data outputs
// R24 - frame valid leads first line by start blank, trails last by 23
`timescale 1ns/100ps
`default_nettype none
`include "srft_defs.vh"

module srft_top (
    input  wire        CLK_I,
    input  wire        RST_I,
    input  wire [7:0]  REG_ADDR_I,
    input  wire [15:0] REG_WDATA_I,
    input  wire        REG_WR_I,
    input  wire        REG_RD_I,
    output reg  [15:0] REG_RDATA_O,
    input  wire        MASTER_CLOCK_IN_I,
    input  wire        OE_I,
    input  wire [9:0]  PIX_VAL_I,
    output reg  [8:0]  PIX_ROW_O,
    output reg  [9:0]  PIX_COL_O,
    output reg  [9:0]  DOUT_O,
    output reg         DOUT_OE_O,
    output reg         LINE_VALID_O,
    output reg         FRAME_VALID_O,
    output reg         SAMPLE_CLOCK_OUT_O
);

    localparam S_VB  = 5'b00001;
    localparam S_P1  = 5'b00010;
    localparam S_ACT = 5'b00100;
    localparam S_HB  = 5'b01000;
    localparam S_P2  = 5'b10000;

    reg [8:0]  rows_ff;
    reg [9:0]  width_ff;
    reg [9:0]  hblank_ff;
    reg [9:0]  vblank_ff;
    reg [11:0] integ_ff;
    reg [3:0]  bin_ff;
    reg [3:0]  ctrl_ff;
    reg        clkinv_ff;
    reg [2:0]  msync_ff;
    reg        mlvl_ff;
    reg [2:0]  oesync_ff;
    reg [1:0]  dcnt_ff;
    reg        pclk_p_ff;
    reg [4:0]  state_ff;
    reg [10:0] cnt_ff;
    reg [12:0] row_ff;
    reg [9:0]  line_ff;
    reg        field_ff;
    reg [9:0]  s_w_ff;
    reg [10:0] s_q_ff;
    reg [9:0]  s_lines_ff;
    reg [3:0]  s_ctrl_ff;
    reg        tick_d1_ff;
    reg        tick_d2_ff;
    reg        blk_ff;
    reg        act_ff;
    reg [13:0] bsum_ff;
    reg [4:0]  bnum_ff;
    reg [9:0]  boff_ff;
    reg [15:0] frames_ff;

    reg [4:0]  nxt_state;
    reg [10:0] nxt_cnt;
    reg [12:0] nxt_row;
    reg [9:0]  nxt_line;
    reg [10:0] lim;
    reg [8:0]  nxt_arow;
    reg [9:0]  nxt_acol;
    reg        nxt_blk;
    reg        nxt_act;
    reg [11:0] arow_w;
    reg [9:0]  lin_r;
    reg [15:0] nxt_rdata;
    reg        nxt_pclk;

    wire [9:0]  w_cl;
    wire [8:0]  r_cl;
    wire [10:0] w_ext;
    wire [10:0] q_eff;
    wire [10:0] rt_live;
    wire [10:0] p1_len;
    wire [12:0] thresh;
    wire [12:0] vrows;
    wire [1:0]  nxt_d;
    wire [1:0]  csh;
    wire [1:0]  rsh;
    wire        mrise;
    wire        tick;
    wire        last;
    wire        frame_start;
    wire        frame_end;
    wire        green_px;
    wire [9:0]  corr;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------

    always @(posedge CLK_I) begin
        if (RST_I) begin
            rows_ff   <= `SRFT_RST_ROWS;
            width_ff  <= `SRFT_RST_WIDTH;
            hblank_ff <= `SRFT_RST_HBLANK;
            vblank_ff <= `SRFT_RST_VBLANK;
            integ_ff  <= `SRFT_RST_INTEG;
            bin_ff    <= 4'h0;
            ctrl_ff   <= `SRFT_RST_CTRL;
            clkinv_ff <= 1'b0;
        end else if (REG_WR_I) begin
            case (REG_ADDR_I)
                `SRFT_A_ROWS:   rows_ff   <= REG_WDATA_I[8:0];
                `SRFT_A_WIDTH:  width_ff  <= REG_WDATA_I[9:0];
                `SRFT_A_HBLANK: hblank_ff <= REG_WDATA_I[9:0];
                `SRFT_A_VBLANK: vblank_ff <= REG_WDATA_I[9:0];
                `SRFT_A_INTEG:  integ_ff  <= REG_WDATA_I[11:0];
                `SRFT_A_BIN:    bin_ff    <= REG_WDATA_I[3:0];
                `SRFT_A_CTRL:   ctrl_ff   <= REG_WDATA_I[3:0];
                `SRFT_A_CLKPOL: clkinv_ff <= REG_WDATA_I[`SRFT_CLKPOL_INV];
                default: ;
            endcase
        end
    end

    // read data next cycle, zero when unmapped
    always @* begin
        nxt_rdata = 16'h0000;
        case (REG_ADDR_I)
            `SRFT_A_ROWS:   nxt_rdata = {7'h00, rows_ff};
            `SRFT_A_WIDTH:  nxt_rdata = {6'h00, width_ff};
            `SRFT_A_HBLANK: nxt_rdata = {6'h00, hblank_ff};
            `SRFT_A_VBLANK: nxt_rdata = {6'h00, vblank_ff};
            `SRFT_A_INTEG:  nxt_rdata = {4'h0, integ_ff};
            `SRFT_A_BIN:    nxt_rdata = {12'h000, bin_ff};
            `SRFT_A_CTRL:   nxt_rdata = {12'h000, ctrl_ff};
            `SRFT_A_CLKPOL: nxt_rdata = {11'h000, clkinv_ff, 4'h0};
            `SRFT_A_STATE:  nxt_rdata = {10'h000, field_ff, state_ff};
            `SRFT_A_FRAMES: nxt_rdata = frames_ff;
            `SRFT_A_BLKOFS: nxt_rdata = {6'h00, boff_ff};
            default:        nxt_rdata = 16'h0000;
        endcase
    end

    always @(posedge CLK_I) begin
        if (RST_I)
            REG_RDATA_O <= 16'h0000;
        else
            REG_RDATA_O <= REG_RD_I ? nxt_rdata : 16'h0000;
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------

    // change counts once stages 2 and 3 agree
    always @(posedge CLK_I) begin
        if (RST_I) begin
            msync_ff  <= 3'h0;
            oesync_ff <= 3'h0;
            mlvl_ff   <= 1'b0;
            DOUT_OE_O <= 1'b0;
        end else begin
            msync_ff  <= {msync_ff[1:0], MASTER_CLOCK_IN_I};
            oesync_ff <= {oesync_ff[1:0], OE_I};
            if (msync_ff[1] == msync_ff[2])
                mlvl_ff <= msync_ff[2];
            // R23 data enable only
            if (oesync_ff[1] == oesync_ff[2])
                DOUT_OE_O <= oesync_ff[2];
        end
    end

    assign mrise = (msync_ff[1] == msync_ff[2]) & msync_ff[2] & ~mlvl_ff;

    // ----------------------------------------------------------------
    // pixel clock generation
    // ----------------------------------------------------------------

    assign csh   = (bin_ff[1:0] == 2'd0) ? 2'd0 : (bin_ff[1:0] == 2'd1) ? 2'd1 : 2'd2;
    assign rsh   = (bin_ff[3:2] == 2'd0) ? 2'd0 : (bin_ff[3:2] == 2'd1) ? 2'd1 : 2'd2;
    assign nxt_d = dcnt_ff + 2'd1;
    // tick lands where pixel clock falls
    assign tick  = mrise & ((csh == 2'd0) | ((csh == 2'd1) & ~nxt_d[0]) |
                            ((csh == 2'd2) & (nxt_d == 2'd0)));

    // R9 inverted master clock
    // R10 divided when column binning
    // R12 polarity flip
    always @* begin
        nxt_pclk = ~mlvl_ff;
        if (csh == 2'd1)
            nxt_pclk = dcnt_ff[0];
        else if (csh == 2'd2)
            nxt_pclk = dcnt_ff[1];
        nxt_pclk = nxt_pclk ^ clkinv_ff;
    end

    // R11 never gated
    // two stages match the data pipeline
    always @(posedge CLK_I) begin
        if (RST_I) begin
            dcnt_ff            <= 2'd0;
            pclk_p_ff          <= 1'b0;
            SAMPLE_CLOCK_OUT_O <= 1'b0;
        end else begin
            if (mrise)
                dcnt_ff <= nxt_d;
            pclk_p_ff          <= nxt_pclk;
            SAMPLE_CLOCK_OUT_O <= pclk_p_ff;
        end
    end

    // ----------------------------------------------------------------
    // frame geometry
    // ----------------------------------------------------------------

    // R3 clamp to active area
    assign w_cl  = (width_ff > `SRFT_ACT_COLS) ? `SRFT_ACT_COLS :
                   (width_ff == 10'd0) ? 10'd1 : width_ff;
    assign r_cl  = (rows_ff > `SRFT_ACT_ROWS) ? `SRFT_ACT_ROWS :
                   (rows_ff == 9'd0) ? 9'd1 : rows_ff;
    assign w_ext = {1'b0, w_cl};
    // R19 stretch short rows
    assign q_eff = (w_ext + {1'b0, hblank_ff} < `SRFT_MIN_ROW) ?
                   (`SRFT_MIN_ROW - w_ext) : {1'b0, hblank_ff};
    // R13 row and start blank
    assign rt_live = w_ext + q_eff;
    assign p1_len  = (q_eff > `SRFT_P2_LEN) ? (q_eff - `SRFT_P2_LEN) : 11'd1;
    // R16 long integration
    // R17 internal extension, register kept
    // R18 exposure untouched here
    assign thresh = {4'h0, r_cl} + {3'h0, vblank_ff};
    assign vrows  = ({1'b0, integ_ff} + `SRFT_OVH_ROWS >= thresh) ?
                    ({1'b0, integ_ff} + `SRFT_OVH_ROWS - {4'h0, r_cl}) :
                    {3'h0, vblank_ff};

    // ----------------------------------------------------------------
    // readout sequencer
    // ----------------------------------------------------------------

    always @* begin
        case (state_ff)
            // R14 blank rows plus 4
            S_VB:    lim = (row_ff == vrows) ? `SRFT_VB_EXTRA : rt_live;
            S_P1:    lim = p1_len;
            S_ACT:   lim = {1'b0, s_w_ff};
            S_HB:    lim = s_q_ff;
            S_P2:    lim = `SRFT_P2_LEN;
            default: lim = 11'd1;
        endcase
    end

    assign last        = (cnt_ff == lim - 11'd1);
    assign frame_start = tick & last & (state_ff == S_VB) & (row_ff == vrows);
    assign frame_end   = tick & last & (state_ff == S_P2);

    // R7 lines framed by blanking
    // R15 frame is lines times row time
    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_row   = row_ff;
        nxt_line  = line_ff;
        if (tick) begin
            nxt_cnt = cnt_ff + 11'd1;
            if (last) begin
                nxt_cnt = 11'd0;
                case (state_ff)
                    S_VB: begin
                        if (row_ff == vrows) begin
                            nxt_state = S_P1;
                            nxt_row   = 13'd0;
                        end else begin
                            nxt_row = row_ff + 13'd1;
                        end
                    end
                    S_P1: begin
                        nxt_state = S_ACT;
                        nxt_line  = 10'd0;
                    end
                    S_ACT: begin
                        nxt_state = (line_ff == s_lines_ff - 10'd1) ? S_P2 : S_HB;
                    end
                    S_HB: begin
                        nxt_state = S_ACT;
                        nxt_line  = line_ff + 10'd1;
                    end
                    S_P2: begin
                        nxt_state = S_VB;
                        nxt_row   = 13'd0;
                    end
                    default: nxt_state = S_VB;
                endcase
            end
        end
    end

    // geometry frozen at frame start
    always @(posedge CLK_I) begin
        if (RST_I) begin
            state_ff   <= S_VB;
            cnt_ff     <= 11'd0;
            row_ff     <= 13'd0;
            line_ff    <= 10'd0;
            field_ff   <= 1'b0;
            s_w_ff     <= `SRFT_RST_WIDTH;
            s_q_ff     <= {1'b0, `SRFT_RST_HBLANK};
            s_lines_ff <= {1'b0, `SRFT_RST_ROWS};
            s_ctrl_ff  <= `SRFT_RST_CTRL;
            frames_ff  <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            row_ff   <= nxt_row;
            line_ff  <= nxt_line;
            if (frame_start) begin
                s_w_ff     <= w_cl;
                s_q_ff     <= q_eff;
                s_ctrl_ff  <= ctrl_ff;
                // R2 four extra black lines
                s_lines_ff <= {1'b0, r_cl} +
                              (ctrl_ff[`SRFT_CTRL_RAW] ? `SRFT_RAW_ROWS : 10'd0);
            end
            if (frame_end) begin
                field_ff  <= ~field_ff;
                frames_ff <= frames_ff + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // array addressing
    // ----------------------------------------------------------------

    always @* begin
        nxt_arow = 9'd0;
        nxt_acol = 10'd0;
        nxt_blk  = 1'b0;
        nxt_act  = 1'b0;
        arow_w   = 12'h000;
        lin_r    = line_ff - (s_ctrl_ff[`SRFT_CTRL_RAW] ? `SRFT_RAW_ROWS : 10'd0);
        if ((state_ff == S_VB) && (row_ff < 13'd4) && (cnt_ff < w_ext)) begin
            // R1 black rows feed the offset internally
            nxt_arow = `SRFT_BLK_MID + {7'h00, row_ff[1:0]};
            nxt_acol = cnt_ff[9:0];
            nxt_blk  = 1'b1;
        end else if (state_ff == S_ACT) begin
            // R5 neighbour columns, no pattern skip
            arow_w   = {2'b00, cnt_ff[9:0]} << csh;
            nxt_acol = `SRFT_BLK_COLS + ((arow_w > 12'd752) ? 10'd752 : arow_w[9:0]);
            if (s_ctrl_ff[`SRFT_CTRL_RAW] && (line_ff < `SRFT_RAW_ROWS)) begin
                // R2 middle black rows
                nxt_arow = `SRFT_BLK_MID + line_ff[8:0];
            end else begin
                // R6 alternate rows per field
                if (s_ctrl_ff[`SRFT_CTRL_ILACE])
                    arow_w = {1'b0, lin_r, 1'b0} + {11'h000, field_ff};
                else
                    arow_w = {2'b00, lin_r} << rsh;
                nxt_arow = `SRFT_BLK_ROWS + ((arow_w > 12'd480) ? 9'd480 : arow_w[8:0]);
                nxt_act  = 1'b1;
            end
        end
    end

    always @(posedge CLK_I) begin
        if (RST_I) begin
            PIX_ROW_O  <= 9'd0;
            PIX_COL_O  <= 10'd0;
            blk_ff     <= 1'b0;
            act_ff     <= 1'b0;
            tick_d1_ff <= 1'b0;
            tick_d2_ff <= 1'b0;
        end else begin
            PIX_ROW_O  <= nxt_arow;
            PIX_COL_O  <= nxt_acol;
            blk_ff     <= nxt_blk;
            act_ff     <= nxt_act;
            tick_d1_ff <= tick;
            tick_d2_ff <= tick_d1_ff;
        end
    end

    // ----------------------------------------------------------------
    // black level
    // ----------------------------------------------------------------

    // first-green: even row, even column
    assign green_px = ~PIX_ROW_O[0] & ~PIX_COL_O[0];

    // R4 offset from green or from all dark pixels
    // R21 one offset for every colour
    // 16 samples keep the divide a shift
    always @(posedge CLK_I) begin
        if (RST_I) begin
            bsum_ff <= 14'd0;
            bnum_ff <= 5'd0;
            boff_ff <= 10'd0;
        end else if (frame_end) begin
            bsum_ff <= 14'd0;
            bnum_ff <= 5'd0;
        end else if (frame_start) begin
            if (bnum_ff == `SRFT_BLK_SAMPLES)
                boff_ff <= bsum_ff[13:4];
        end else if (tick_d2_ff && blk_ff && (bnum_ff != `SRFT_BLK_SAMPLES) &&
                     (green_px || !ctrl_ff[`SRFT_CTRL_COLOR])) begin
            bsum_ff <= bsum_ff + {4'h0, PIX_VAL_I};
            bnum_ff <= bnum_ff + 5'd1;
        end
    end

    assign corr = (PIX_VAL_I > boff_ff) ? (PIX_VAL_I - boff_ff) : 10'd0;

    // ----------------------------------------------------------------
    // parallel output
    // ----------------------------------------------------------------

    // R8 one word per pixel period
    // R24 frame valid spans start blank to end blank
    always @(posedge CLK_I) begin
        if (RST_I) begin
            DOUT_O        <= 10'd0;
            LINE_VALID_O  <= 1'b0;
            FRAME_VALID_O <= 1'b0;
        end else if (tick_d2_ff) begin
            LINE_VALID_O  <= (state_ff == S_ACT);
            FRAME_VALID_O <= (state_ff != S_VB);
            if (state_ff == S_ACT)
                DOUT_O <= act_ff ? corr : PIX_VAL_I;
            else
                DOUT_O <= 10'd0;
        end
    end

endmodule // srft_top
`default_nettype wire

// *** pkg/srft_defs.vh ***
`ifndef SRFT_DEFS_VH
`define SRFT_DEFS_VH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define SRFT_ARR_COLS    10'd782
`define SRFT_ARR_ROWS    9'd492
`define SRFT_BLK_COLS    10'd26
`define SRFT_BLK_ROWS    9'd8
`define SRFT_BLK_MID     9'd2
`define SRFT_RAW_ROWS    10'd4
`define SRFT_ACT_COLS    10'd753
`define SRFT_ACT_ROWS    9'd481

// ----------------------------------------------------------------
// frame timing counts, in pixel clocks except the row overhead (rows) and black sample count
// ----------------------------------------------------------------
`define SRFT_P2_LEN      11'd23
`define SRFT_VB_EXTRA    11'd4
`define SRFT_OVH_ROWS    13'd2
`define SRFT_MIN_ROW     11'd660
`define SRFT_BLK_SAMPLES 5'd16

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SRFT_A_ROWS      8'h03
`define SRFT_A_WIDTH     8'h04
`define SRFT_A_HBLANK    8'h05
`define SRFT_A_VBLANK    8'h06
`define SRFT_A_INTEG     8'h0B
`define SRFT_A_BIN       8'h0D
`define SRFT_A_CTRL      8'h0F
`define SRFT_A_CLKPOL    8'h74
`define SRFT_A_STATE     8'h80
`define SRFT_A_FRAMES    8'h81
`define SRFT_A_BLKOFS    8'h82

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SRFT_CTRL_RAW    0
`define SRFT_CTRL_ILACE  1
`define SRFT_CTRL_COLOR  2
`define SRFT_CTRL_SIMUL  3
`define SRFT_CLKPOL_INV  4
`define SRFT_RST_ROWS    9'd480
`define SRFT_RST_WIDTH   10'd752
`define SRFT_RST_HBLANK  10'd94
`define SRFT_RST_VBLANK  10'd45
`define SRFT_RST_INTEG   12'd480
`define SRFT_RST_CTRL    4'h0

`endif

// *** tb/srft_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------
// host capture, run lengths per frame
// ------
module srft_host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        chk_i,
    input  wire logic        pclk_i,
    input  wire logic        fv_i,
    input  wire logic        lv_i,
    input  wire logic [9:0]  d_i,
    output logic             done_o,
    output logic [5:0][15:0] len_o,
    output logic [15:0]      bad_o
);
    logic        pc_ff;
    logic [1:0]  st_ff;
    logic [15:0] run_ff;
    logic        same;
    logic [9:0]  k;
    assign same = (st_ff == {fv_i, lv_i});
    assign k = same ? run_ff[9:0] : 10'h000;
    // len: vblank, start, line, gap, end, lines
    always_ff @(posedge clk_i) begin
        pc_ff <= pclk_i;
        done_o <= 1'b0;
        if (rst_i) begin
            st_ff <= 2'b00;
            run_ff <= 16'h0000;
            bad_o <= 16'h0000;
            len_o <= '0;
        end else if (pclk_i && !pc_ff) begin
            // raw lines 0-3 black, then ramp
            if (chk_i && lv_i && d_i !== (len_o[5] < 16'h4 ? 10'h020 : k + 10'h03A))
                bad_o <= bad_o + 16'h1;
            run_ff <= same ? run_ff + 16'h1 : 16'h1;
            st_ff <= {fv_i, lv_i};
            case ({st_ff, fv_i, lv_i})
                4'b0010: begin
                    len_o[0] <= run_ff;
                    len_o[5] <= 16'h0;
                end
                4'b1011: len_o[(len_o[5] == 16'h0) ? 1 : 3] <= run_ff;
                4'b1110: begin
                    len_o[2] <= run_ff;
                    len_o[5] <= len_o[5] + 16'h1;
                end
                4'b1000: begin
                    len_o[4] <= run_ff;
                    done_o <= 1'b1;
                end
                default: ;
            endcase
        end
    end
endmodule // srft_host_model
`default_nettype wire

// *** tb/srft_top_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "srft_defs.vh"
// ------
// port checker
// ------
module srft_top_chk (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        REG_RD_I,
    input wire logic [15:0] REG_RDATA_O,
    input wire logic        OE_I,
    input wire logic [8:0]  PIX_ROW_O,
    input wire logic [9:0]  PIX_COL_O,
    input wire logic [9:0]  DOUT_O,
    input wire logic        DOUT_OE_O,
    input wire logic        LINE_VALID_O,
    input wire logic        FRAME_VALID_O,
    input wire logic        SAMPLE_CLOCK_OUT_O
);
    logic       pc_ff;
    logic [5:0] hold_ff;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // cycles since pixel clock moved
    always_ff @(posedge CLK_I) begin
        pc_ff <= SAMPLE_CLOCK_OUT_O;
        if (RST_I || pc_ff != SAMPLE_CLOCK_OUT_O)
            hold_ff <= 6'h00;
        else if (hold_ff != 6'h3F)
            hold_ff <= hold_ff + 6'h01;
    end
    // properties
    property p_rd_idle; !$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_lv_in_fv; LINE_VALID_O |-> FRAME_VALID_O; endproperty
    a_lv_in_fv: assert property (p_lv_in_fv)
        else $error("line valid outside frame");
    property p_lead; $rose(LINE_VALID_O) |-> $past(FRAME_VALID_O, 8); endproperty
    a_lead: assert property (p_lead)
        else $error("no frame lead");
    property p_trail; $fell(FRAME_VALID_O) |-> !$past(LINE_VALID_O, 8); endproperty
    a_trail: assert property (p_trail)
        else $error("no frame trail");
    property p_blank; !LINE_VALID_O |-> DOUT_O == 10'h000; endproperty
    a_blank: assert property (p_blank)
        else $error("data in blanking");
    property p_hold;
        LINE_VALID_O && $past(LINE_VALID_O) && $changed(DOUT_O) |=> $stable(DOUT_O) [*3];
    endproperty
    a_hold: assert property (p_hold)
        else $error("pixel too short");
    property p_runs; hold_ff < 6'd40; endproperty
    a_runs: assert property (p_runs)
        else $error("pixel clock stopped");
    property p_oe_on; $rose(OE_I) |-> ##[2:6] DOUT_OE_O; endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("data not driven");
    property p_oe_off; $fell(OE_I) |-> ##[2:6] !DOUT_OE_O; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("data not released");
    property p_geom; PIX_ROW_O < `SRFT_ARR_ROWS && PIX_COL_O < `SRFT_ARR_COLS; endproperty
    a_geom: assert property (p_geom)
        else $error("address off array");
endmodule // srft_top_chk
bind srft_top srft_top_chk u_srft_top_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .OE_I(OE_I), .PIX_ROW_O(PIX_ROW_O), .PIX_COL_O(PIX_COL_O), .DOUT_O(DOUT_O),
    .DOUT_OE_O(DOUT_OE_O), .LINE_VALID_O(LINE_VALID_O), .FRAME_VALID_O(FRAME_VALID_O),
    .SAMPLE_CLOCK_OUT_O(SAMPLE_CLOCK_OUT_O));
`default_nettype wire

// *** tb/srft_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module srft_top_tb;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic [7:0]       addr = 8'h00;
    logic [15:0]      wdata = 16'h0000;
    logic             wr_s = 1'b0;
    logic             rd_s = 1'b0;
    logic             mclk = 1'b0;
    logic             oe = 1'b1;
    logic             chk_on = 1'b0;
    logic [15:0]      rdata;
    logic [15:0]      bad;
    logic [9:0]       pix_val, pix_col, dout;
    logic [8:0]       pix_row;
    logic             doe, lv, fv, sco, done;
    logic [5:0][15:0] len;
    logic [63:0]      sv;
    int               error_cnt = 0;
    int               n_checks = 0;
    int               i, j, k, w, hb, qe, hi;
    logic [7:0]       ra [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h0B, 8'h0D, 8'h0F, 8'h40};
    logic [15:0]      rv [8] = '{16'h01E0, 16'h02F0, 16'h005E, 16'h002D,
                                 16'h01E0, 16'h0000, 16'h0000, 16'h0000};
    // black rows flat, image a ramp
    assign pix_val = (pix_row < 9'd8) ? 10'h020 : pix_col + 10'h040;
    initial forever #25 clk = ~clk;
    // master clock, 400 ns
    initial begin
        #13;
        forever #200 mclk = ~mclk;
    end
    srft_top u_srft_top (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .MASTER_CLOCK_IN_I(mclk),
        .OE_I(oe), .PIX_VAL_I(pix_val), .PIX_ROW_O(pix_row), .PIX_COL_O(pix_col),
        .DOUT_O(dout), .DOUT_OE_O(doe), .LINE_VALID_O(lv), .FRAME_VALID_O(fv),
        .SAMPLE_CLOCK_OUT_O(sco));
    srft_host_model u_srft_host_model (.clk_i(clk), .rst_i(rst), .chk_i(chk_on),
        .pclk_i(sco), .fv_i(fv), .lv_i(lv), .d_i(dout), .done_o(done), .len_o(len),
        .bad_o(bad));
    // ------
    // helpers
    // ------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
        @(posedge clk);
    endtask
    task automatic do_reset(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
    endtask
    // 0: frame done, 1: frame valid
    task automatic wait_for(input int which, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(negedge clk);
            if ((which == 0) ? (done === 1'b1) : (fv === 1'b1))
                break;
        end
        if (n == lim)
            chk(16'h0001, 16'h0000);
        @(posedge clk);
    endtask
    task automatic chk_frame(input int vb, input int nl);
        chk(len[0], 16'(vb));
        chk(len[1], 16'(qe - 23));
        chk(len[2], 16'(w));
        chk(len[3], 16'(qe));
        chk(len[4], 16'h0017);
        chk(len[5], 16'(nl));
    endtask
    task automatic close_out;
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------
    // tests
    // ------
    initial begin
        void'($urandom(32'hB1BF2DD7));
        do_reset(12);
        for (i = 0; i < 8; i++)
            rd(ra[i], rv[i]);
        do_reset(4);
        w = 100 + $urandom % 200;
        hb = 43 + $urandom % 20;
        qe = (hb > 660 - w) ? hb : 660 - w;
        wr(8'h06, 16'h0000);
        wr(8'h0B, 16'h0000);
        wr(8'h03, 16'h0002);
        wr(8'h04, 16'(w));
        wr(8'h05, 16'(hb));
        wait_for(1, 2000);
        wr(8'h0B, 16'h0004);
        wait_for(0, 15000);
        wait_for(1, 25000);
        // next frame: one row, raw, colour
        wr(8'h03, 16'h0001);
        wr(8'h06, 16'h0001);
        wr(8'h0B, 16'h0000);
        wr(8'h0F, 16'h0005);
        oe <= 1'b0;
        repeat (10) @(posedge clk);
        #1 chk(16'(doe), 16'h0000);
        @(posedge clk);
        oe <= 1'b1;
        wait_for(0, 15000);
        chk_frame(4 * (w + qe) + 4, 2);
        chk_on <= 1'b1;
        wait_for(0, 40000);
        chk_frame(w + qe + 4, 5);
        chk(bad, 16'h0000);
        rd(8'h82, 16'h0020);
        // pixel clock per bin, last inverted
        for (i = 0; i < 4; i++) begin
            do_reset(4);
            wr(8'h06, 16'h0000);
            wr(8'h0B, 16'h0000);
            wr(8'h0D, 16'(i % 3));
            wr(8'h74, (i == 3) ? 16'h0010 : 16'h0000);
            wait_for(1, 3000);
            for (k = 0; k < 64; k++) begin
                @(negedge clk);
                sv[k] = sco;
            end
            hi = 0;
            for (k = 1; k < 63; k++)
                if (sv[k] && !sv[k - 1])
                    break;
            for (j = k; j < 64 && sv[j] === 1'b1; j++)
                hi++;
            chk(16'(hi), 16'(4 << (i % 3)));
            if (i == 0 || i == 3) begin
                @(posedge mclk);
                #325 chk(16'(sco), (i == 3) ? 16'h0001 : 16'h0000);
            end
            @(posedge clk);
        end
        close_out();
    end
    // hang guard
    initial begin
        #4500000;
        error_cnt++;
        close_out();
    end
endmodule // srft_top_tb
`default_nettype wire
